// ==== include/pace_defs.svh ====
// Purpose: offsets, field positions, reset values and timing constants
// Assumes: byte addresses on a 32-bit register port
// Notes:   definitions only
`ifndef PACE_DEFS_SVH
`define PACE_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFF_SOFT_RESET   8'h04
`define OFF_PACE_CTRL    8'h0c
`define OFF_THR_EN_C0    8'h10
`define OFF_THR_EN_C1    8'h20
`define OFF_THR_EN_C2    8'h30
`define OFF_RX_MAX_C0    8'h70
`define OFF_TX_MAX_C0    8'h74
`define OFF_MAX_STRIDE   8'h08

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define PACE_EN_LSB      16
`define PACE_EN_MSB      21
`define PRESCALE_MSB     11
`define CTRL_RESET       32'h00000000
`define THR_RESET        8'h00
`define MAX_RESET        6'h00

// ---------------------------------------------------------------
// timing: one pacing window is 1 ms of 4 us ticks
// ---------------------------------------------------------------
`define TICK_NS          4000
`define MS_NS            1000000
`define TICKS_PER_MS     (`MS_NS / `TICK_NS)

`endif

// ==== include/pace_pkg.sv ====
// Purpose: shared types for the pacing block
// Assumes: nothing
// Notes:   constants live in pace_defs.svh
package pace_pkg;
  typedef logic [11:0] prescale_t;
  typedef logic [7:0]  chan_mask_t;
  typedef logic [5:0]  rate_t;
  typedef enum logic [1:0] {
    PACE_OPEN = 2'b01,
    PACE_FULL = 2'b10
  } pace_state_e;
endpackage

// ==== core/pace_gate.sv ====
// Purpose: paces one core/direction pulse stream to a per-ms rate
// Assumes: ms_tick is a one-cycle pulse each pacing window
// Notes:   rate zero lets no paced pulse through while pace_enable is set
module pace_gate
  import pace_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  reset,
  input  wire logic  sw_clear,
  // control
  input  wire logic  pace_enable,
  input  wire rate_t max_rate,
  input  wire logic  ms_tick,
  // pulses
  input  wire logic  raw_pulse,
  output logic       paced_pulse
);
  pace_state_e state;
  rate_t       sent;

  // count pulses released in this window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sent  <= 6'h00;
      state <= PACE_OPEN;
    end else if (sw_clear || ms_tick) begin
      sent  <= 6'h00;
      state <= PACE_OPEN;
    end else begin
      case (state)
        PACE_OPEN: begin
          if (raw_pulse && pace_enable) begin
            sent <= sent + 6'h01;
            if (sent + 6'h01 >= max_rate)
              state <= PACE_FULL;
          end
        end
        PACE_FULL: state <= PACE_FULL;
        default:   state <= PACE_OPEN;
      endcase
    end
  end

  // registered output, pass-through when pacing is off
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      paced_pulse <= 1'b0;
    else
      paced_pulse <= raw_pulse && !sw_clear &&
                     (!pace_enable || (state == PACE_OPEN && max_rate != 6'h00));
  end
endmodule // pace_gate

// ==== core/pace_ctrl.sv ====
// Purpose: interrupt pacing control and rx threshold enables, 3 cores
// Assumes: register port strobes are one cycle; read data next cycle
// Notes:   pacing arithmetic is per core/direction in pace_gate
//
// The register addresses and strobed register access were chosen for this implementation.
`include "pace_defs.svh"
module pace_ctrl
  import pace_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // rx threshold events, 8 channels per core
  input  wire logic [23:0] rx_threshold_event,
  output logic      [2:0]  rx_threshold_pulse,
  // raw rx/tx pulses per core, paced versions out
  input  wire logic [2:0]  rx_raw_pulse,
  input  wire logic [2:0]  tx_raw_pulse,
  output logic      [2:0]  rx_paced_pulse,
  output logic      [2:0]  tx_paced_pulse,
  // timebase
  output logic             tick_4us
);
  logic [5:0]  pace_en;        // {c2tx,c2rx,c1tx,c1rx,c0tx,c0rx}
  prescale_t   tick_prescale_count;
  chan_mask_t  thr_en [3];
  rate_t       rx_max_rate_per_ms [3];
  rate_t       tx_max_rate_per_ms [3];
  logic        soft_clear;
  prescale_t   tick_cnt;
  logic [7:0]  ms_cnt;
  logic        ms_tick;

  // write decode helper used by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // soft reset
  // ---------------------------------------------------------------
  // clear next cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      soft_clear <= 1'b0;
    else
      soft_clear <= reg_write && hit(reg_addr, `OFF_SOFT_RESET) && reg_wdata[0];
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // pacing enables and prescale
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pace_en             <= 6'h00;
      tick_prescale_count <= 12'h000;
    end else if (soft_clear) begin
      pace_en             <= 6'h00;
      tick_prescale_count <= 12'h000;
    end else if (reg_write && hit(reg_addr, `OFF_PACE_CTRL)) begin
      pace_en             <= reg_wdata[`PACE_EN_MSB:`PACE_EN_LSB];
      tick_prescale_count <= reg_wdata[`PRESCALE_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // per-core threshold enables and max-rate registers
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_core
      localparam logic [7:0] THR_OFF = `OFF_THR_EN_C0 + 8'(c) * 8'h10;
      localparam logic [7:0] RXM_OFF = `OFF_RX_MAX_C0 + 8'(c) * `OFF_MAX_STRIDE;
      localparam logic [7:0] TXM_OFF = `OFF_TX_MAX_C0 + 8'(c) * `OFF_MAX_STRIDE;
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          thr_en[c]             <= `THR_RESET;
          rx_max_rate_per_ms[c] <= `MAX_RESET;
          tx_max_rate_per_ms[c] <= `MAX_RESET;
        end else if (soft_clear) begin
          thr_en[c]             <= `THR_RESET;
          rx_max_rate_per_ms[c] <= `MAX_RESET;
          tx_max_rate_per_ms[c] <= `MAX_RESET;
        end else if (reg_write) begin
          if (hit(reg_addr, THR_OFF)) thr_en[c] <= reg_wdata[7:0];
          if (hit(reg_addr, RXM_OFF)) rx_max_rate_per_ms[c] <= reg_wdata[5:0];
          if (hit(reg_addr, TXM_OFF)) tx_max_rate_per_ms[c] <= reg_wdata[5:0];
        end
      end
      // gated threshold pulse, quiet while soft clear runs
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset)
          rx_threshold_pulse[c] <= 1'b0;
        else
          rx_threshold_pulse[c] <= !soft_clear &&
                                   |(rx_threshold_event[c*8 +: 8] & thr_en[c]);
      end
      pace_gate u_rx (
        .core_clk    (core_clk),
        .reset       (reset),
        .sw_clear    (soft_clear),
        .pace_enable (pace_en[2*c]),
        .max_rate    (rx_max_rate_per_ms[c]),
        .ms_tick     (ms_tick),
        .raw_pulse   (rx_raw_pulse[c]),
        .paced_pulse (rx_paced_pulse[c])
      );
      pace_gate u_tx (
        .core_clk    (core_clk),
        .reset       (reset),
        .sw_clear    (soft_clear),
        .pace_enable (pace_en[2*c+1]),
        .max_rate    (tx_max_rate_per_ms[c]),
        .ms_tick     (ms_tick),
        .raw_pulse   (tx_raw_pulse[c]),
        .paced_pulse (tx_paced_pulse[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  // reload counter for 4 us tick
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 12'h000;
      tick_4us <= 1'b0;
    end else if (soft_clear) begin
      tick_cnt <= 12'h000;
      tick_4us <= 1'b0;
    end else if (tick_cnt == 12'h000) begin
      tick_cnt <= tick_prescale_count;
      tick_4us <= (tick_prescale_count != 12'h000);
    end else begin
      tick_cnt <= tick_cnt - 12'h001;
      tick_4us <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ms_cnt  <= 8'h00;
      ms_tick <= 1'b0;
    end else if (soft_clear) begin
      ms_cnt  <= 8'h00;
      ms_tick <= 1'b0;
    end else if (tick_4us && ms_cnt == 8'(`TICKS_PER_MS - 1)) begin
      ms_cnt  <= 8'h00;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= tick_4us ? ms_cnt + 8'h01 : ms_cnt;
      ms_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // reserved bits zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (!reg_read)
      reg_rdata <= 32'h00000000;
    else begin
      case (reg_addr)
        `OFF_PACE_CTRL: reg_rdata <= {10'h000, pace_en, 4'h0, tick_prescale_count};
        `OFF_THR_EN_C0: reg_rdata <= {24'h000000, thr_en[0]};
        `OFF_THR_EN_C1: reg_rdata <= {24'h000000, thr_en[1]};
        `OFF_THR_EN_C2: reg_rdata <= {24'h000000, thr_en[2]};
        8'h70:          reg_rdata <= {26'h0000000, rx_max_rate_per_ms[0]};
        8'h74:          reg_rdata <= {26'h0000000, tx_max_rate_per_ms[0]};
        8'h78:          reg_rdata <= {26'h0000000, rx_max_rate_per_ms[1]};
        8'h7c:          reg_rdata <= {26'h0000000, tx_max_rate_per_ms[1]};
        8'h80:          reg_rdata <= {26'h0000000, rx_max_rate_per_ms[2]};
        8'h84:          reg_rdata <= {26'h0000000, tx_max_rate_per_ms[2]};
        default:        reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule // pace_ctrl

// ==== verification/pace_ctrl_checker.sv ====
// Purpose: port assertions for pace_ctrl
// Assumes: one clock, async active-high reset
// Notes:   bound to every pace_ctrl instance
`include "pace_defs.svh"
module pace_ctrl_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // pulses and timebase
  input wire logic [23:0] rx_threshold_event,
  input wire logic [2:0]  rx_threshold_pulse,
  input wire logic [2:0]  rx_raw_pulse,
  input wire logic [2:0]  tx_raw_pulse,
  input wire logic [2:0]  rx_paced_pulse,
  input wire logic [2:0]  tx_paced_pulse,
  input wire logic        tick_4us
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rdata_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_ctrl_resv; reg_read && reg_addr == `OFF_PACE_CTRL
    |=> reg_rdata[31:22] == 10'h0 && reg_rdata[15:12] == 4'h0; endproperty
  a_ctrl_resv: assert property (p_ctrl_resv) else $error("control reserved bits set");
  property p_thr_resv; reg_read && reg_addr[3:0] == 4'h0 && reg_addr[7:4] inside {1, 2, 3}
    |=> reg_rdata[31:8] == 24'h0; endproperty
  a_thr_resv: assert property (p_thr_resv) else $error("threshold reserved bits set");
  property p_zero_read; reg_read && reg_addr inside {8'h00, `OFF_SOFT_RESET}
    |=> reg_rdata == 32'h0; endproperty
  a_zero_read: assert property (p_zero_read) else $error("write-only place read nonzero");
  property p_thr_cause; (rx_threshold_pulse & {|$past(rx_threshold_event[23:16]),
    |$past(rx_threshold_event[15:8]), |$past(rx_threshold_event[7:0])}) == rx_threshold_pulse;
  endproperty
  a_thr_cause: assert property (p_thr_cause) else $error("threshold pulse without event");
  property p_rx_cause; (rx_paced_pulse & ~$past(rx_raw_pulse)) == 3'h0; endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx paced pulse without raw");
  property p_tx_cause; (tx_paced_pulse & ~$past(tx_raw_pulse)) == 3'h0; endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx paced pulse without raw");
  property p_tick_gap; tick_4us |=> !tick_4us; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick longer than one cycle");
  property p_soft_clear; reg_write && reg_addr == `OFF_SOFT_RESET && reg_wdata[0]
    |=> ##1 (!tick_4us && rx_threshold_pulse == 3'h0) [*2]; endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset left activity");
  // main scenarios seen
  c_thr: cover property (rx_threshold_pulse != 3'h0);
  c_tick: cover property (tick_4us);
  c_paced: cover property (rx_paced_pulse[0]);
endmodule // pace_ctrl_checker

bind pace_ctrl pace_ctrl_checker pace_ctrl_checker_i (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .rx_threshold_event(rx_threshold_event),
  .rx_threshold_pulse(rx_threshold_pulse), .rx_raw_pulse(rx_raw_pulse),
  .tx_raw_pulse(tx_raw_pulse), .rx_paced_pulse(rx_paced_pulse),
  .tx_paced_pulse(tx_paced_pulse), .tick_4us(tick_4us));

// ==== verification/pace_ctrl_test.sv ====
// Purpose: self-checking bench for pace_ctrl
// Assumes: 100 MHz core_clk, async high reset
// Notes:   random stimulus from a fixed seed
`include "pace_defs.svh"
module pace_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] rx_threshold_event = 24'h0;
  logic [2:0]  rx_raw_pulse = 3'h0;
  logic [2:0]  tx_raw_pulse = 3'h0;
  logic [2:0]  rx_threshold_pulse, rx_paced_pulse, tx_paced_pulse;
  logic        tick_4us;
  logic [31:0] d;
  logic [23:0] en;
  int          n_fail = 0, num_checks = 0, g, c, i, n_rx0, n_tx0, n_raw1, n_out1;

  pace_ctrl pace_ctrl_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_threshold_event(rx_threshold_event), .rx_threshold_pulse(rx_threshold_pulse),
    .rx_raw_pulse(rx_raw_pulse), .tx_raw_pulse(tx_raw_pulse), .rx_paced_pulse(rx_paced_pulse),
    .tx_paced_pulse(tx_paced_pulse), .tick_4us(tick_4us));

  always #5 core_clk = ~core_clk;

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // one-cycle read, data taken in the next cycle
  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(name, exp, reg_rdata);
  endtask
  // clocks until the next tick, capped
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (tick_4us !== 1'b1 && n < 3000);
  endtask
  function automatic logic [2:0] exp_thr(logic [23:0] ev, logic [23:0] m);
    for (int k = 0; k < 3; k++) exp_thr[k] = |(ev[k*8 +: 8] & m[k*8 +: 8]);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog well past the expected run
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(37));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(`OFF_PACE_CTRL, 32'h0, "ctrl reset");
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h0, "unmapped");
    rd(`OFF_SOFT_RESET, 32'h0, "soft reset read");
    repeat (8) begin
      d = $urandom & 32'hfffff7ff;
      wr(`OFF_PACE_CTRL, d);
      rd(`OFF_PACE_CTRL, d & 32'h003f07ff, "ctrl");
      for (c = 0; c < 3; c++) begin
        wr(`OFF_THR_EN_C0 + 8'(c * 16), d >> c);
        rd(`OFF_THR_EN_C0 + 8'(c * 16), (d >> c) & 32'hff, "thr en");
      end
    end
    $display("test registers done");
    en = {8'($urandom), 8'($urandom), 8'h80};
    for (c = 0; c < 3; c++) wr(`OFF_THR_EN_C0 + 8'(c * 16), {24'h0, en[c*8 +: 8]});
    repeat (32) begin
      d = $urandom;
      @(posedge core_clk);
      rx_threshold_event <= d[23:0];
      @(posedge core_clk);
      #1 check("thr pulse", {29'h0, exp_thr(d[23:0], en)}, {29'h0, rx_threshold_pulse});
    end
    rx_threshold_event <= 24'h0;
    $display("test threshold done");
    // tick period is prescale plus one
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 32'h1 : (j == 1) ? 32'h3 : 32'h7ff;
      wr(`OFF_PACE_CTRL, d);
      tick_gap(g);
      tick_gap(g);
      check("tick period", d + 1, 32'(g));
    end
    wr(`OFF_PACE_CTRL, 32'h0);
    tick_gap(g);
    tick_gap(g);
    check("no tick at zero", 32'd3000, 32'(g));
    $display("test tick done");
    // core0 paced rx 3 tx 0, cores 1 and 2 open
    wr(`OFF_RX_MAX_C0, 32'h3);
    wr(`OFF_TX_MAX_C0, 32'h0);
    wr(`OFF_PACE_CTRL, 32'h00030001);
    n_rx0 = 0;
    n_tx0 = 0;
    n_raw1 = 0;
    n_out1 = 0;
    for (i = 0; i < 302; i++) begin
      d = (i % 2 == 0 && i < 300) ? $urandom : 32'h0;
      @(posedge core_clk);
      rx_raw_pulse <= {d[2], d[0], |d[1:0]};
      tx_raw_pulse <= {d[3], d[1], |d[1:0]};
      #1;
      n_raw1 += int'(d[0]) + int'(d[1]) + int'(d[2]) + int'(d[3]);
      n_rx0 += int'(rx_paced_pulse[0]);
      n_tx0 += int'(tx_paced_pulse[0]);
      n_out1 += int'(rx_paced_pulse[1]) + int'(tx_paced_pulse[1]);
      n_out1 += int'(rx_paced_pulse[2]) + int'(tx_paced_pulse[2]);
    end
    check("rx paced in window", 32'h1, 32'(n_rx0 >= 3 && n_rx0 <= 6));
    check("tx paced rate zero", 32'h0, 32'(n_tx0));
    check("unpaced pass", 32'(n_raw1), 32'(n_out1));
    $display("test pacing done");
    wr(`OFF_SOFT_RESET, 32'h1);
    rd(`OFF_PACE_CTRL, 32'h0, "ctrl after soft");
    rd(`OFF_THR_EN_C0, 32'h0, "thr after soft");
    rd(`OFF_RX_MAX_C0, 32'h0, "rx max after soft");
    $display("test soft reset done");
    stop_test();
  end
endmodule // pace_ctrl_test
